// File: pkg/cwg_consts.vh
// Constants for the complementary waveform generator: register offsets,
// field positions, mode codes and reset values.
// Assumes inclusion by bare name from the design file.
`ifndef CWG_CONSTS_VH
`define CWG_CONSTS_VH

`define OFS_CONTROL_0 12'h000
`define OFS_CONTROL_1 12'h004
`define OFS_CLOCK_CONTROL 12'h008
`define OFS_INPUT_SELECT 12'h00C
`define OFS_RISE_DEADBAND 12'h010
`define OFS_FALL_DEADBAND 12'h014
`define OFS_STEER_CONTROL 12'h018
`define OFS_SHUTDOWN_0 12'h01C
`define OFS_SHUTDOWN_1 12'h020

`define CON0_EN_BIT 7
`define CON0_LD_BIT 6
`define CON0_MODE_HI 2
`define CON0_MODE_LO 0
`define CON1_OUT_BIT 5

`define AS0_SHUTDOWN_BIT 7
`define AS0_RESTART_BIT 6
`define AS0_OVR_BD_HI 5
`define AS0_OVR_BD_LO 4
`define AS0_OVR_AC_HI 3
`define AS0_OVR_AC_LO 2

`define MODE_STEER_ASYNC 3'h0
`define MODE_STEER_SYNC 3'h1
`define MODE_FULL_FWD 3'h2
`define MODE_FULL_REV 3'h3
`define MODE_HALF 3'h4
`define MODE_PUSH_PULL 3'h5

`define OVR_INACTIVE 2'h0
`define OVR_TRISTATE 2'h1
`define OVR_LOW 2'h2
`define OVR_HIGH 2'h3

`define INT_OSC_HZ 16000000
`define INPUT_SOURCE_COUNT 14

`define RESET_CONTROL_0 8'h00
`define RESET_CONTROL_1 8'h00
`define RESET_WORD 32'h00000000

`endif

// File: logic/complementary_waveform_gen.v
// Complementary waveform generator with an AHB-Lite register slave.
// Assumes all source inputs and shutdown inputs are synchronous to hclk,
// and that the fast oscillator arrives as an enable tick in hclk domain.
//
// Contract
// - Six modes chosen by control mode field
// - Half-bridge: A true, B inverted, dead-band
// - Half-bridge C, D mirror with own polarity
// - Push-pull alternates input pulses between A, B
// - Push-pull sequencer resets on disable or shutdown
// - Sequencer advances per pulse; first to A
// - Push-pull C copies A, D copies B
// - Forward full-bridge: A active, D modulated
// - Reverse full-bridge: C active, B modulated
// - Full-bridge dead-band only on direction change
// - Direction toggles via mode bit zero live
// - Steering routes input to any outputs
// - Synchronous steering applies on rising input
// - Asynchronous steering applies next cycle
// - Clock-select bit picks system or oscillator
// - Input select picks one of fourteen sources
// - Separate six-bit rise and fall dead-band timers
// - Auto-shutdown with sources, restart, override levels
// - Dead-band counts from zero to register value
// - Enabled dead-band loads on falling input after load
// - Unsteered outputs hold level; steered follow input
// - Polarity sets active level, not overrides
//
// The placing of the registers and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/10ps
`include "cwg_consts.vh"

module complementary_waveform_gen #(
	parameter DB_WIDTH = 6
) (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output wire [31:0] hrdata,
	output wire hreadyout,
	output wire hresp,
	input wire internal_fast_osc,
	input wire gen_input_pin,
	input wire [1:0] ccp_out,
	input wire [3:0] pwm_out,
	input wire num_osc_output,
	input wire comparator1_synced,
	input wire comparator2_synced,
	input wire [3:0] logic_cell_out,
	input wire timer2_postscaled,
	output reg out_a,
	output reg out_b,
	output reg out_c,
	output reg out_d,
	output reg [3:0] out_oe_n
);

	// ==========================================================
	// Register slave.
	reg [7:0] gen_control_0;
	reg [7:0] gen_control_1;
	reg gen_clock_control;
	reg [3:0] input_select_reg;
	reg [DB_WIDTH-1:0] rise_deadband_reg;
	reg [DB_WIDTH-1:0] fall_deadband_reg;
	reg [7:0] steer_control;
	reg [7:0] shutdown_0;
	reg [3:0] shutdown_1;
	reg wr_pend;
	reg [11:0] wr_addr;
	reg [31:0] rd_data;
	wire addr_phase;
	wire [2:0] mode;
	wire enable;
	wire [3:0] out_polarity_bits;
	wire [3:0] steer_bits;
	wire shut_event;
	reg shutdown_state;
	reg in_sel;
	wire cur_out;
	reg in_prev;
	wire in_rise;
	wire in_fall;

	assign addr_phase = hsel & hready & htrans[1];
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = rd_data;
	assign mode = gen_control_0[`CON0_MODE_HI:`CON0_MODE_LO];
	assign enable = gen_control_0[`CON0_EN_BIT];
	assign out_polarity_bits = gen_control_1[3:0];
	assign steer_bits = steer_control[3:0];

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			wr_addr <= 12'h000;
			rd_data <= `RESET_WORD;
		end else begin
			wr_pend <= addr_phase & hwrite;
			wr_addr <= haddr[11:0];
			rd_data <= `RESET_WORD;
			if (addr_phase & !hwrite) begin
				case (haddr[11:0])
					`OFS_CONTROL_0: rd_data <= {24'h000000, gen_control_0};
					`OFS_CONTROL_1: rd_data <= {24'h000000, 2'h0,
						cur_out, 1'b0, gen_control_1[3:0]};
					`OFS_CLOCK_CONTROL: rd_data <= {31'h00000000, gen_clock_control};
					`OFS_INPUT_SELECT: rd_data <= {28'h0000000, input_select_reg};
					`OFS_RISE_DEADBAND: rd_data <= {26'h0000000, rise_deadband_reg};
					`OFS_FALL_DEADBAND: rd_data <= {26'h0000000, fall_deadband_reg};
					`OFS_STEER_CONTROL: rd_data <= {24'h000000, steer_control};
					`OFS_SHUTDOWN_0: rd_data <= {24'h000000, shutdown_state,
						shutdown_0[6:0]};
					`OFS_SHUTDOWN_1: rd_data <= {28'h0000000, shutdown_1};
					default: rd_data <= `RESET_WORD;
				endcase
			end
		end
	end

	// ==========================================================
	// Input source selection.
	always @* begin
		case (input_select_reg)
			4'h0: in_sel = gen_input_pin;
			4'h1: in_sel = ccp_out[0];
			4'h2: in_sel = ccp_out[1];
			4'h3: in_sel = pwm_out[0];
			4'h4: in_sel = pwm_out[1];
			4'h5: in_sel = pwm_out[2];
			4'h6: in_sel = pwm_out[3];
			4'h7: in_sel = num_osc_output;
			4'h8: in_sel = comparator1_synced;
			4'h9: in_sel = comparator2_synced;
			4'hA: in_sel = logic_cell_out[0];
			4'hB: in_sel = logic_cell_out[1];
			4'hC: in_sel = logic_cell_out[2];
			4'hD: in_sel = logic_cell_out[3];
			default: in_sel = 1'b0;
		endcase
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			in_prev <= 1'b0;
		end else begin
			in_prev <= in_sel;
		end
	end
	assign in_rise = in_sel & ~in_prev;
	assign in_fall = ~in_sel & in_prev;

	// ==========================================================
	// Generator clock tick: system clock or oscillator tick.
	wire gen_tick;
	assign gen_tick = gen_clock_control ? internal_fast_osc : 1'b1;

	// ==========================================================
	// Writable registers, dead-band buffers and shutdown state.
	reg [DB_WIDTH-1:0] rise_active;
	reg [DB_WIDTH-1:0] fall_active;
	reg load_armed;
	wire soft_shut_set;
	wire [3:0] shut_inputs_low;

	assign soft_shut_set = wr_pend && wr_addr == `OFS_SHUTDOWN_0 &&
		hwdata[`AS0_SHUTDOWN_BIT];
	// The four shutdown input sources are active low; the mask picks which count.
	assign shut_inputs_low = shutdown_1 & ~{timer2_postscaled, gen_input_pin,
		comparator2_synced, comparator1_synced};
	assign shut_event = |shut_inputs_low | shutdown_0[`AS0_SHUTDOWN_BIT] | soft_shut_set;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			gen_control_0 <= `RESET_CONTROL_0;
			gen_control_1 <= `RESET_CONTROL_1;
			gen_clock_control <= 1'b0;
			input_select_reg <= 4'h0;
			rise_deadband_reg <= {DB_WIDTH{1'b0}};
			fall_deadband_reg <= {DB_WIDTH{1'b0}};
			rise_active <= {DB_WIDTH{1'b0}};
			fall_active <= {DB_WIDTH{1'b0}};
			steer_control <= 8'h00;
			shutdown_0 <= 8'h00;
			shutdown_1 <= 4'h0;
			load_armed <= 1'b0;
			shutdown_state <= 1'b0;
		end else begin
			if (wr_pend) begin
				case (wr_addr)
					`OFS_CONTROL_0: gen_control_0 <= hwdata[7:0];
					`OFS_CONTROL_1: gen_control_1 <= {4'h0, hwdata[3:0]};
					`OFS_CLOCK_CONTROL: gen_clock_control <= hwdata[0];
					`OFS_INPUT_SELECT: input_select_reg <= hwdata[3:0];
					`OFS_RISE_DEADBAND: rise_deadband_reg <= hwdata[DB_WIDTH-1:0];
					`OFS_FALL_DEADBAND: fall_deadband_reg <= hwdata[DB_WIDTH-1:0];
					`OFS_STEER_CONTROL: steer_control <= hwdata[7:0];
					`OFS_SHUTDOWN_0: shutdown_0 <= hwdata[7:0];
					`OFS_SHUTDOWN_1: shutdown_1 <= hwdata[3:0];
					default: ;
				endcase
			end
			// While disabled the buffers pass straight through.
			if (!enable) begin
				rise_active <= rise_deadband_reg;
				fall_active <= fall_deadband_reg;
				load_armed <= 1'b0;
			end else begin
				if (gen_control_0[`CON0_LD_BIT])
					load_armed <= 1'b1;
				if (load_armed && in_fall) begin
					rise_active <= rise_deadband_reg;
					fall_active <= fall_deadband_reg;
					load_armed <= 1'b0;
					gen_control_0[`CON0_LD_BIT] <= 1'b0;
				end
			end
			// Auto-restart leaves shutdown on the first rising input once
			// every source is quiet; without it the state clears once every source is quiet.
			if (shut_event) begin
				shutdown_state <= 1'b1;
			end else if (shutdown_state && shutdown_0[`AS0_RESTART_BIT] && in_rise) begin
				shutdown_state <= 1'b0;
			end else if (!shutdown_0[`AS0_RESTART_BIT]) begin
				shutdown_state <= 1'b0;
			end
			if (shutdown_state && shutdown_0[`AS0_RESTART_BIT] && in_rise &&
				!(|shut_inputs_low) && !soft_shut_set)
				shutdown_0[`AS0_SHUTDOWN_BIT] <= 1'b0;
		end
	end

	// ==========================================================
	// Dead-band timers, push-pull sequencer and steering latch.
	reg [DB_WIDTH-1:0] rise_count;
	reg [DB_WIDTH-1:0] fall_count;
	reg rise_busy;
	reg fall_busy;
	reg pp_toggle;
	reg pp_pulse_a;
	reg [3:0] steer_live;
	reg dir_rev;
	reg dir_busy;
	reg [DB_WIDTH-1:0] dir_count;
	wire full_mode;
	wire rise_done;
	wire fall_done;
	wire dir_done;

	assign full_mode = mode == `MODE_FULL_FWD || mode == `MODE_FULL_REV;
	assign rise_done = rise_count >= rise_active;
	assign fall_done = fall_count >= fall_active;
	assign dir_done = dir_count >= (dir_rev ? rise_active : fall_active);

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rise_count <= {DB_WIDTH{1'b0}};
			fall_count <= {DB_WIDTH{1'b0}};
			rise_busy <= 1'b0;
			fall_busy <= 1'b0;
			pp_toggle <= 1'b0;
			pp_pulse_a <= 1'b1;
			steer_live <= 4'h0;
			dir_rev <= 1'b0;
			dir_busy <= 1'b0;
			dir_count <= {DB_WIDTH{1'b0}};
		end else begin
			// Timers restart on each edge so a short pulse yields nothing.
			if (in_rise) begin
				rise_busy <= 1'b1;
				rise_count <= {DB_WIDTH{1'b0}};
			end else if (rise_busy && gen_tick && !rise_done) begin
				rise_count <= rise_count + 1'b1;
			end
			if (in_fall) begin
				fall_busy <= 1'b1;
				fall_count <= {DB_WIDTH{1'b0}};
			end else if (fall_busy && gen_tick && !fall_done) begin
				fall_count <= fall_count + 1'b1;
			end
			if (!enable || shutdown_state) begin
				pp_toggle <= 1'b0;
				pp_pulse_a <= 1'b1;
			end else if (in_rise) begin
				pp_pulse_a <= ~pp_toggle;
				pp_toggle <= ~pp_toggle;
			end
			// A direction change takes effect at the next rising input.
			if (full_mode && in_rise && dir_rev != mode[0]) begin
				dir_rev <= mode[0];
				dir_busy <= 1'b1;
				dir_count <= {DB_WIDTH{1'b0}};
			end else if (dir_busy && gen_tick) begin
				if (dir_done)
					dir_busy <= 1'b0;
				else
					dir_count <= dir_count + 1'b1;
			end
			if (mode == `MODE_STEER_ASYNC || (mode == `MODE_STEER_SYNC && in_rise))
				steer_live <= steer_bits;
		end
	end

	// ==========================================================
	// Output formation, polarity and override.
	reg [3:0] raw_active;
	wire [3:0] next_pins;
	wire [3:0] next_oe_n;
	reg [3:0] shut_mask;
	wire shut_now;
	wire [1:0] ovr_ac;
	wire [1:0] ovr_bd;
	wire half_a;
	wire half_b;

	assign ovr_ac = shutdown_0[`AS0_OVR_AC_HI:`AS0_OVR_AC_LO];
	assign ovr_bd = shutdown_0[`AS0_OVR_BD_HI:`AS0_OVR_BD_LO];
	// The edge cycle still sees the count of the previous edge, so it is masked.
	assign half_a = in_sel & ~in_rise & rise_busy & rise_done;
	assign half_b = ~in_sel & ~in_fall & fall_busy & fall_done;
	// Without auto-restart the shutdown is a level that ends with its causes.
	assign shut_now = shut_event | (shutdown_state & shutdown_0[`AS0_RESTART_BIT]);

	always @* begin
		raw_active = 4'h0;
		shut_mask = 4'hF;
		case (mode)
			`MODE_HALF: raw_active = {half_b, half_a, half_b, half_a};
			`MODE_PUSH_PULL: begin
				raw_active[0] = in_sel & (in_rise ? ~pp_toggle : pp_pulse_a);
				raw_active[1] = in_sel & ~(in_rise ? ~pp_toggle : pp_pulse_a);
				raw_active[2] = raw_active[0];
				raw_active[3] = raw_active[1];
			end
			`MODE_FULL_FWD, `MODE_FULL_REV: begin
				raw_active[0] = ~dir_rev;
				raw_active[2] = dir_rev;
				raw_active[3] = ~dir_rev & in_sel & ~dir_busy;
				raw_active[1] = dir_rev & in_sel & ~dir_busy;
			end
			`MODE_STEER_ASYNC, `MODE_STEER_SYNC: begin
				shut_mask = (mode == `MODE_STEER_ASYNC || in_rise) ? steer_bits : steer_live;
				raw_active = shut_mask & {4{in_sel}};
			end
			default: raw_active = 4'h0;
		endcase
	end

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_pin
			wire [1:0] ovr;
			reg pin_v;
			reg oe_n_v;
			assign ovr = (gi % 2 == 1) ? ovr_bd : ovr_ac;
			assign next_pins[gi] = pin_v;
			assign next_oe_n[gi] = oe_n_v;
			always @* begin
				// Unsteered pins hold their level in the inactive state.
				oe_n_v = ~enable;
				pin_v = out_polarity_bits[gi] ? raw_active[gi] : ~raw_active[gi];
				if (enable && shut_now && shut_mask[gi]) begin
					case (ovr)
						`OVR_INACTIVE: pin_v = ~out_polarity_bits[gi];
						`OVR_TRISTATE: oe_n_v = 1'b1;
						`OVR_LOW: pin_v = 1'b0;
						`OVR_HIGH: pin_v = 1'b1;
						default: pin_v = 1'b0;
					endcase
				end
			end
		end
	endgenerate

	assign cur_out = out_a;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			out_a <= 1'b0;
			out_b <= 1'b0;
			out_c <= 1'b0;
			out_d <= 1'b0;
			out_oe_n <= 4'hF;
		end else begin
			out_a <= next_pins[0];
			out_b <= next_pins[1];
			out_c <= next_pins[2];
			out_d <= next_pins[3];
			out_oe_n <= next_oe_n;
		end
	end

endmodule // complementary_waveform_gen

// File: verif/cwg_chk.sv
// Checker for the waveform generator, bound to its top-level ports.
// Assumes registers change only through AHB-Lite writes, which it shadows.
`timescale 1ns/10ps
`include "cwg_consts.vh"
module cwg_chk #(
	parameter DB_WIDTH = 6
) (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [31:0] hwdata,
	input wire hready,
	input wire gen_input_pin,
	input wire out_a,
	input wire out_b,
	input wire out_c,
	input wire out_d,
	input wire [3:0] out_oe_n
);
	// ==========
	// Register shadows
	// The quiet count stands in for output latency after any write.
	logic wr_ph;
	logic [11:0] wa;
	logic [7:0] con0, con1, steer, sd0, sd1;
	logic [5:0] quiet;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			{wr_ph, wa, con0, con1, steer, sd0, sd1, quiet} <= '0;
		end else begin
			wr_ph <= hsel && hready && htrans[1] && hwrite;
			wa <= haddr[11:0];
			quiet <= wr_ph ? 6'h00 : quiet + {5'h00, quiet != 6'h3F};
			if (wr_ph && wa == `OFS_CONTROL_0) con0 <= hwdata[7:0];
			if (wr_ph && wa == `OFS_CONTROL_1) con1 <= hwdata[7:0];
			if (wr_ph && wa == `OFS_STEER_CONTROL) steer <= hwdata[7:0];
			if (wr_ph && wa == `OFS_SHUTDOWN_0) sd0 <= hwdata[7:0];
			if (wr_ph && wa == `OFS_SHUTDOWN_1) sd1 <= hwdata[7:0];
		end
	end
	wire [2:0] mode = con0[2:0];
	wire run = con0[7] && !sd0[7] && sd1[3:0] == 4'h0 && quiet >= 6'h04;
	wire settled = run && quiet >= 6'h28;
	wire pol_hi = con1[3:0] == 4'hF;
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// ==========
	// Properties
	sequence s_steered_rise;
		settled && mode[2:1] == 2'h0 && steer[0] && con1[0] ##0 $rose(gen_input_pin);
	endsequence
	sequence s_follow;
		##[1:3] out_a;
	endsequence
	property p_off;
		!con0[7] && quiet >= 6'h04 |-> out_oe_n == 4'hF;
	endproperty
	a_off: assert property (p_off) else $error("driven while disabled");
	property p_fwd;
		settled && pol_hi && mode == `MODE_FULL_FWD |-> {out_c, out_b, out_a} == 3'b001;
	endproperty
	a_fwd: assert property (p_fwd) else $error("forward levels wrong");
	property p_rev;
		settled && pol_hi && mode == `MODE_FULL_REV |-> {out_d, out_c, out_a} == 3'b010;
	endproperty
	a_rev: assert property (p_rev) else $error("reverse levels wrong");
	property p_half_gap;
		run && pol_hi && mode == `MODE_HALF |-> !(out_a && out_b);
	endproperty
	a_half_gap: assert property (p_half_gap) else $error("half-bridge overlap");
	property p_mirror;
		run && (mode == `MODE_HALF || mode == `MODE_PUSH_PULL) |->
			out_c == (out_a ^ con1[0] ^ con1[2]) && out_d == (out_b ^ con1[1] ^ con1[3]);
	endproperty
	a_mirror: assert property (p_mirror) else $error("c or d not a copy");
	property p_pp_excl;
		run && pol_hi && mode == `MODE_PUSH_PULL |-> !(out_a && out_b);
	endproperty
	a_pp_excl: assert property (p_pp_excl) else $error("push-pull overlap");
	property p_steer_hold;
		settled && mode[2:1] == 2'h0 && !steer[0] |-> $stable(out_a);
	endproperty
	a_steer_hold: assert property (p_steer_hold) else $error("unsteered output moved");
	property p_steer_follow;
		s_steered_rise |-> s_follow;
	endproperty
	a_steer_follow: assert property (p_steer_follow) else $error("steered output idle");
endmodule // cwg_chk

bind complementary_waveform_gen cwg_chk #(.DB_WIDTH(DB_WIDTH)) u_chk (.hclk(hclk),
	.hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
	.hwdata(hwdata), .hready(hready), .gen_input_pin(gen_input_pin), .out_a(out_a),
	.out_b(out_b), .out_c(out_c), .out_d(out_d), .out_oe_n(out_oe_n));

// File: verif/gate_driver_model.sv
// Gate driver stand-in: counts switch-on events of each output, byte per
// output with A lowest. Assumes outputs change on hclk edges.
`timescale 1ns/10ps
module gate_driver_model (
	input wire hclk,
	input wire clr,
	input wire [3:0] gate,
	input wire [3:0] gate_oe_n,
	output logic [31:0] ons
);
	// ==========
	// Edge counting
	// A released output is not a switch-on, so its enable gates the count.
	logic [3:0] prev;
	always @(posedge hclk) begin
		prev <= gate;
		for (int i = 0; i < 4; i++) begin
			if (clr) ons[i*8 +: 8] <= 8'h00;
			else if (gate[i] && !prev[i] && !gate_oe_n[i]) ons[i*8 +: 8] <= ons[i*8 +: 8] + 8'h01;
		end
	end
endmodule // gate_driver_model

// File: verif/tb_top.sv
// Self-checking bench for the waveform generator.
// Assumes the bound checker and a gate driver model on the outputs.
`timescale 1ns/10ps
`include "cwg_consts.vh"
module tb_top;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic clr = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] rd_s;
	logic [13:0] src = 14'h0;
	wire [31:0] hrdata, ons;
	wire hreadyout, out_a, out_b, out_c, out_d;
	wire [3:0] out_oe_n;
	wire [3:0] outs = {out_d, out_c, out_b, out_a};
	int failures = 0;
	int num_checks = 0;
	always #2.5 hclk = ~hclk;
	always @(posedge hclk) rd_s <= hrdata;
	complementary_waveform_gen dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .internal_fast_osc(1'b0),
		.gen_input_pin(src[0]), .ccp_out(src[2:1]), .pwm_out(src[6:3]), .num_osc_output(src[7]),
		.comparator1_synced(src[8]), .comparator2_synced(src[9]), .logic_cell_out(src[13:10]),
		.timer2_postscaled(1'b1), .out_a(out_a), .out_b(out_b), .out_c(out_c), .out_d(out_d),
		.out_oe_n(out_oe_n));
	gate_driver_model drv (.hclk(hclk), .clr(clr), .gate(outs), .gate_oe_n(out_oe_n), .ons(ons));
	// ==========
	// Shared tasks
	task automatic finish_test;
		if (failures == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic stuck;
		failures++;
		finish_test;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge hclk);
	endtask
	// Read data is taken from a copy sampled at the edge, which avoids a race.
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {20'h0, a};
		repeat (2) begin
			@(posedge hclk);
			while (hreadyout !== 1'b1) begin
				if (++n > 50) stuck;
				@(posedge hclk);
			end
			hsel <= 1'b0;
			htrans <= 2'h0;
			hwdata <= d;
		end
		@(negedge hclk);
		q = rd_s;
		@(posedge hclk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(q & m, e);
	endtask
	task automatic look(input logic [3:0] m, input logic [3:0] e);
		@(negedge hclk);
		chk({28'h0, outs & m}, {28'h0, e});
		@(posedge hclk);
	endtask
	task automatic pulses(input int n);
		repeat (n) begin
			src[0] <= 1'b1;
			tick(8);
			src[0] <= 1'b0;
			tick(8);
		end
	endtask
	task automatic fresh;
		clr <= 1'b1;
		tick(1);
		clr <= 1'b0;
	endtask
	// ==========
	// Scenarios
	task automatic t_regs;
		rd(`OFS_CONTROL_0, 32'hFF, 32'h0);
		wr(`OFS_RISE_DEADBAND, 32'hFFFFFFFF);
		rd(`OFS_RISE_DEADBAND, 32'hFFFFFFFF, 32'h3F);
		wr(`OFS_FALL_DEADBAND, 32'hFF);
		rd(`OFS_FALL_DEADBAND, 32'hFFFFFFFF, 32'h3F);
		wr(12'h040, 32'hFFFFFFFF);
		rd(12'h040, 32'hFFFFFFFF, 32'h0);
		wr(`OFS_CLOCK_CONTROL, 32'h3);
		rd(`OFS_CLOCK_CONTROL, 32'hFFFFFFFF, 32'h1);
		wr(`OFS_CLOCK_CONTROL, 32'h0);
		wr(`OFS_CONTROL_1, 32'hF);
		rd(`OFS_CONTROL_1, 32'hF, 32'hF);
	endtask
	task automatic t_bridge;
		wr(`OFS_RISE_DEADBAND, 32'h0);
		wr(`OFS_FALL_DEADBAND, 32'h0);
		wr(`OFS_CONTROL_0, 32'h82);
		pulses(3);
		look(4'hF, 4'h1);
		wr(`OFS_CONTROL_0, 32'h83);
		pulses(3);
		look(4'hF, 4'h4);
	endtask
	task automatic t_push_pull;
		wr(`OFS_CONTROL_0, 32'h0);
		wr(`OFS_CONTROL_0, 32'h85);
		fresh;
		pulses(3);
		chk(ons, 32'h01020102);
		wr(`OFS_CONTROL_0, 32'h05);
		wr(`OFS_CONTROL_0, 32'h85);
		fresh;
		pulses(1);
		chk(ons, 32'h00010001);
	endtask
	// The rise delay is compared between two settings, so fixed latency cancels.
	task automatic t_half;
		int d[4];
		for (int i = 0; i < 4; i++) begin
			if (i < 2) begin
				wr(`OFS_CONTROL_0, 32'h0);
				wr(`OFS_RISE_DEADBAND, i ? 32'h2 : 32'h5);
				wr(`OFS_FALL_DEADBAND, 32'h5);
				wr(`OFS_CONTROL_0, 32'h84);
			end else if (i == 2) begin
				// While running, a new value waits for the load bit and a falling input.
				wr(`OFS_RISE_DEADBAND, 32'h5);
				wr(`OFS_CONTROL_0, 32'hC4);
			end
			tick(20);
			src[0] <= 1'b1;
			d[i] = 0;
			@(negedge hclk);
			while (out_a !== 1'b1) begin
				if (++d[i] > 100) stuck;
				@(negedge hclk);
			end
			@(posedge hclk);
			src[0] <= 1'b0;
			tick(20);
			look(4'h3, 4'h2);
		end
		chk(32'(d[0] - d[1]), 32'h3);
		chk(32'(d[2]), 32'(d[1]));
		chk(32'(d[3]), 32'(d[0]));
	endtask
	task automatic t_steer;
		logic [3:0] s [6];
		s = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h5, 4'hF};
		wr(`OFS_CONTROL_0, 32'h80);
		src[0] <= 1'b1;
		foreach (s[i]) begin
			wr(`OFS_STEER_CONTROL, 32'(s[i]));
			look(s[i], s[i]);
			pulses(4);
			src[0] <= 1'b1;
			tick(3);
		end
		wr(`OFS_CONTROL_0, 32'h81);
		wr(`OFS_STEER_CONTROL, 32'h0);
		look(4'hF, 4'hF);
		src[0] <= 1'b0;
	endtask
	task automatic t_inputs;
		wr(`OFS_CONTROL_0, 32'h80);
		wr(`OFS_STEER_CONTROL, 32'h1);
		for (int i = 0; i < 14; i++) begin
			wr(`OFS_INPUT_SELECT, 32'(i));
			src <= 14'h1 << i;
			tick(4);
			look(4'h1, 4'h1);
			src <= 14'h0;
			tick(4);
			look(4'h1, 4'h0);
		end
		wr(`OFS_INPUT_SELECT, 32'h0);
	endtask
	task automatic t_shutdown;
		src[0] <= 1'b1;
		wr(`OFS_STEER_CONTROL, 32'hF);
		wr(`OFS_SHUTDOWN_0, 32'hAC);
		look(4'hF, 4'h5);
		wr(`OFS_CONTROL_1, 32'h0);
		look(4'hF, 4'h5);
		wr(`OFS_CONTROL_1, 32'hF);
		wr(`OFS_SHUTDOWN_0, 32'h2C);
		look(4'hF, 4'hF);
		src[8] <= 1'b0;
		wr(`OFS_SHUTDOWN_1, 32'h1);
		look(4'hF, 4'h5);
		src[8] <= 1'b1;
		wr(`OFS_SHUTDOWN_0, 32'h2C);
		look(4'hF, 4'hF);
		wr(`OFS_SHUTDOWN_1, 32'h0);
	endtask
	initial begin
		tick(10);
		hresetn <= 1'b1;
		tick(1);
		t_regs;
		t_bridge;
		t_push_pull;
		t_half;
		t_steer;
		t_inputs;
		t_shutdown;
		finish_test;
	end
endmodule // tb_top
